// ---- hw/ssw_pkg.sv ----
// package: constants and carrier types for the switch serial control and status block
package ssw_pkg;
  localparam int SSW_WORD_BITS = 16;
  localparam int SSW_NUM_OUT = 12;
  localparam int SSW_NUM_HS = 4;
  localparam logic [2:0] SSW_ADDR_OUTPUT_CTRL = 3'h0;
  localparam logic [2:0] SSW_ADDR_OPEN_LOAD_CONFIG = 3'h1;
  localparam logic [2:0] SSW_ADDR_UNUSED_SLOT = 3'h3;
  localparam logic [2:0] SSW_ADDR_CURRENT_LIMIT_CONFIG = 3'h5;
  localparam logic [2:0] SSW_ADDR_TEST_RESERVED = 3'h7;
  localparam int SSW_ADDR_MSB = 14;
  localparam int SSW_ADDR_LSB = 12;
  localparam int SSW_WD_BIT = 15;
  localparam logic [11:0] SSW_CONFIG_RESET = 12'h000;
  localparam logic [11:0] SSW_ALL_FAULTS = 12'hFFF;
  localparam logic [4:0] SSW_BITCNT_RESET = 5'h00;

  // analog condition inputs per output, plus one overvoltage flag for all outputs
  typedef struct packed {
    logic [11:0] open_load;
    logic [11:0] over_temp;
    logic [11:0] output_on;
    logic over_voltage;
  } ssw_sense_t;

  // configuration decoded toward the power stage
  typedef struct packed {
    logic [3:0] hs_open_load_disable;
    logic [7:0] ls_open_load_enable;
    logic [3:0] hs_sustain_limit;
    logic [7:0] ls_latch_off_enable;
  } ssw_config_t;

  // supply state from the undervoltage comparators
  typedef struct packed {
    logic below_upper;
    logic below_lower;
  } ssw_supply_t;
endpackage : ssw_pkg

// ---- hw/ssw_sync.sv ----
// two flip-flop synchroniser for one level input
`timescale 1ns/1ps
`default_nettype none
module ssw_sync #(
  // level held during reset; must match the idle level of the pin
  parameter logic RESET_LEVEL = 1'b0
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // level in and out
  input wire logic din,
  output logic dout
);
  logic meta_reg;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= RESET_LEVEL;
      dout <= RESET_LEVEL;
    end else begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end
endmodule : ssw_sync
`default_nettype wire

// ---- hw/ssw_fault_bit.sv ----
// one latched fault flag: set wins over rearm
`timescale 1ns/1ps
`default_nettype none
module ssw_fault_bit (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // control
  input wire logic clear,
  input wire logic set,
  // state
  output logic flag
);
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clear) begin
      flag <= 1'b0;
    end
  end
endmodule : ssw_fault_bit
`default_nettype wire

// ---- hw/ssw_serial_status.sv ----
// serial control and status logic of a twelve channel power switch
`timescale 1ns/1ps
`default_nettype none
module ssw_serial_status
  import ssw_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // serial link from the host
  input wire logic chip_select_n,
  input wire logic serial_clock,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe_n,
  // direct pins mirrored in the status word
  input wire logic direct_high_side_input_0,
  input wire logic direct_high_side_input_1,
  input wire logic direct_high_side_input_2,
  input wire logic direct_high_side_input_3,
  input wire logic fail_safe_input,
  input wire logic wake_input,
  // analog conditions and supply
  input wire ssw_pkg::ssw_sense_t sense,
  input wire ssw_pkg::ssw_supply_t supply,
  // configuration and control toward the power stage
  output ssw_pkg::ssw_config_t config_out,
  output logic [11:0] output_control_register,
  output logic outputs_enable,
  // fault indication, open drain
  output logic fault_flag_pin,
  output logic fault_flag_pin_oe_n
);
  import ssw_pkg::*;

  // synchronised link pins
  logic cs_n_s;
  logic sclk_s;
  logic si_s;
  // chip select idles high; a low reset level would fake a frame start
  ssw_sync #(.RESET_LEVEL(1'b1)) u_sync_cs (.clock(clock), .resetn(resetn), .din(chip_select_n),
                                           .dout(cs_n_s));
  ssw_sync u_sync_sck (.clock(clock), .resetn(resetn), .din(serial_clock), .dout(sclk_s));
  ssw_sync u_sync_si (.clock(clock), .resetn(resetn), .din(serial_in), .dout(si_s));

  // direct pins pass two flip-flops as well
  logic [5:0] pins_raw;
  logic [5:0] pins_s;
  assign pins_raw = {direct_high_side_input_0, direct_high_side_input_1, fail_safe_input,
                     direct_high_side_input_2, direct_high_side_input_3, wake_input};
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_pin_sync
      ssw_sync u_sync (.clock(clock), .resetn(resetn), .din(pins_raw[gi]), .dout(pins_s[gi]));
    end
  endgenerate

  // supply comparators are analog, synchronised too
  logic uv_upper_s;
  logic uv_lower_s;
  ssw_sync u_sync_uvu (.clock(clock), .resetn(resetn), .din(supply.below_upper),
                       .dout(uv_upper_s));
  ssw_sync u_sync_uvl (.clock(clock), .resetn(resetn), .din(supply.below_lower),
                       .dout(uv_lower_s));

  // analog sense levels come from outside the clock domain as well
  ssw_sense_t sense_s;
  generate
    for (gi = 0; gi < $bits(ssw_sense_t); gi++) begin : g_sense_sync
      ssw_sync u_sync (.clock(clock), .resetn(resetn), .din(sense[gi]), .dout(sense_s[gi]));
    end
  endgenerate

  logic cs_n_d_reg;
  logic sclk_d_reg;
  logic [15:0] rx_reg;
  logic [15:0] tx_reg;
  logic [4:0] bitcnt_reg;
  logic len_ok_reg;
  logic wd_echo_reg;
  logic [11:0] open_load_config;
  logic [11:0] current_limit_config;
  logic [11:0] out_ctrl_reg;
  logic so_reg;
  logic so_oe_n_reg;
  logic fault_pin_reg;
  logic outputs_en_reg;
  logic [11:0] was_on_reg;
  logic [11:0] fault_flags;

  // edge detection on the sampled link
  wire cs_fall = cs_n_d_reg & ~cs_n_s;
  wire cs_rise = ~cs_n_d_reg & cs_n_s;
  wire in_frame = ~cs_n_s & ~cs_n_d_reg;
  wire sck_rise = in_frame & ~sclk_d_reg & sclk_s;
  wire sck_fall = in_frame & sclk_d_reg & ~sclk_s;

  // decode of the received word
  wire [2:0] rx_addr = rx_reg[SSW_ADDR_MSB:SSW_ADDR_LSB];
  wire [11:0] rx_data = rx_reg[11:0];
  wire word_ok = cs_rise & len_ok_reg;
  wire wr_out_ctrl = word_ok & (rx_addr == SSW_ADDR_OUTPUT_CTRL);
  wire wr_open_load = word_ok & (rx_addr == SSW_ADDR_OPEN_LOAD_CONFIG);
  wire wr_cur_limit = word_ok & (rx_addr == SSW_ADDR_CURRENT_LIMIT_CONFIG);
  wire reinit = uv_lower_s;

  // mirror bits chosen by the echo bit
  wire [2:0] mirror = wd_echo_reg ? pins_s[2:0] : pins_s[5:3];
  wire [15:0] status_word = {wd_echo_reg, mirror, fault_flags};

  // overtemperature while on or on since the last complete frame; current limit has no input here
  wire [11:0] ot_set = sense_s.over_temp & (sense_s.output_on | was_on_reg);
  // open-load only while off and detection enabled
  wire [11:0] ol_enable = {open_load_config[11:4], ~open_load_config[3:0]};
  wire [11:0] ol_set = sense_s.open_load & ~sense_s.output_on & ol_enable;
  wire [11:0] ov_set = sense_s.over_voltage ? SSW_ALL_FAULTS : 12'h000;
  wire [11:0] fault_set = ot_set | ol_set | ov_set;
  // read after switch-on clears the open-load bit
  wire [11:0] on_clear = {12{cs_fall}} & sense_s.output_on & ~ot_set;
  wire [11:0] fault_clear = {12{cs_rise | reinit}} | on_clear;
  wire any_fault = |fault_flags | |fault_set;

  generate
    for (gi = 0; gi < SSW_NUM_OUT; gi++) begin : g_fault
      ssw_fault_bit u_fault (
        .clock(clock),
        .resetn(resetn),
        .clear(fault_clear[gi]),
        .set(fault_set[gi] & ~reinit),
        .flag(fault_flags[gi])
      );
    end
  endgenerate

  // link edge history
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cs_n_d_reg <= 1'b1;
      sclk_d_reg <= 1'b0;
    end else begin
      cs_n_d_reg <= cs_n_s;
      sclk_d_reg <= sclk_s;
    end
  end

  // receive on rising serial clock edges
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rx_reg <= 16'h0000;
      bitcnt_reg <= SSW_BITCNT_RESET;
      len_ok_reg <= 1'b0;
    end else if (cs_fall) begin
      bitcnt_reg <= SSW_BITCNT_RESET;
      len_ok_reg <= 1'b0;
    end else if (sck_rise) begin
      rx_reg <= {rx_reg[14:0], si_s};
      bitcnt_reg <= (bitcnt_reg == 5'h0F) ? 5'h10 : {1'b0, bitcnt_reg[3:0] + 4'h1};
      len_ok_reg <= (bitcnt_reg[3:0] == 4'hF);
    end
  end

  // transmit: load on fall, shift MSB first, then pass input through
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tx_reg <= 16'h0000;
    end else if (cs_fall) begin
      tx_reg <= status_word;
    end else if (sck_rise) begin
      tx_reg <= {tx_reg[14:0], si_s};
    end
  end

  // serial output changes on falling edge, floats outside a frame
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      so_reg <= 1'b0;
      so_oe_n_reg <= 1'b1;
    end else if (cs_n_s) begin
      so_oe_n_reg <= 1'b1;
    end else if (cs_fall) begin
      so_reg <= status_word[15];
      so_oe_n_reg <= 1'b0;
    end else if (sck_fall) begin
      so_reg <= tx_reg[15];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      open_load_config <= SSW_CONFIG_RESET;
      current_limit_config <= SSW_CONFIG_RESET;
      out_ctrl_reg <= SSW_CONFIG_RESET;
      wd_echo_reg <= 1'b0;
    end else if (reinit) begin
      open_load_config <= SSW_CONFIG_RESET;
      current_limit_config <= SSW_CONFIG_RESET;
      out_ctrl_reg <= SSW_CONFIG_RESET;
      wd_echo_reg <= 1'b0;
    end else begin
      if (wr_open_load) begin
        open_load_config <= rx_data;
      end
      if (wr_cur_limit) begin
        current_limit_config <= rx_data;
      end
      if (wr_out_ctrl) begin
        out_ctrl_reg <= rx_data;
        wd_echo_reg <= rx_reg[SSW_WD_BIT];
      end
    end
  end

  // outputs that were on since the last complete frame, for overtemperature latching
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      was_on_reg <= 12'h000;
    end else if (word_ok) begin
      was_on_reg <= sense_s.output_on;
    end else begin
      was_on_reg <= was_on_reg | sense_s.output_on;
    end
  end

  // outputs off below the upper threshold, state kept
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      outputs_en_reg <= 1'b0;
    end else begin
      outputs_en_reg <= ~uv_upper_s;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      fault_pin_reg <= 1'b1;
    end else begin
      fault_pin_reg <= ~any_fault;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      config_out <= '0;
      output_control_register <= 12'h000;
    end else begin
      config_out <= {open_load_config[3:0], open_load_config[11:4],
                     current_limit_config[3:0], current_limit_config[11:4]};
      output_control_register <= out_ctrl_reg;
    end
  end

  assign outputs_enable = outputs_en_reg;
  assign serial_out = so_reg;
  assign serial_out_oe_n = so_oe_n_reg;
  assign fault_flag_pin = 1'b0;
  assign fault_flag_pin_oe_n = fault_pin_reg;

  a_len_guard : assert property (@(posedge clock) disable iff (!resetn)
    (cs_rise && !len_ok_reg) |=> $stable(open_load_config) && $stable(current_limit_config))
    else $error("configuration changed on a short frame");
  // test and unused addresses leave registers alone
  a_test_addr : assert property (@(posedge clock) disable iff (!resetn)
    (cs_rise && (rx_addr == SSW_ADDR_TEST_RESERVED || rx_addr == SSW_ADDR_UNUSED_SLOT) && !reinit)
    |=> $stable(open_load_config) && $stable(current_limit_config) && $stable(out_ctrl_reg))
    else $error("reserved address altered a register");
  a_ol_write : assert property (@(posedge clock) disable iff (!resetn)
    (wr_open_load && !reinit) |=> open_load_config == $past(rx_data))
    else $error("open-load config not written");
  // current limit write reaches the power stage two cycles on
  a_cl_out : assert property (@(posedge clock) disable iff (!resetn)
    (wr_cur_limit && !reinit) |-> ##2 config_out.hs_sustain_limit == $past(rx_data[3:0], 2))
    else $error("sustain limit not forwarded");
  // output floats after chip select rise
  a_so_float : assert property (@(posedge clock) disable iff (!resetn)
    cs_rise |=> serial_out_oe_n)
    else $error("serial output still driven after frame");
  // first bit driven on chip select fall
  a_first_bit : assert property (@(posedge clock) disable iff (!resetn)
    cs_fall |=> (serial_out == $past(status_word[15])) && !serial_out_oe_n)
    else $error("first status bit wrong");
  a_ov_all : assert property (@(posedge clock) disable iff (!resetn)
    (sense_s.over_voltage && !reinit) |=> fault_flags == SSW_ALL_FAULTS)
    else $error("overvoltage not flagged on all outputs");
  a_fault_pin : assert property (@(posedge clock) disable iff (!resetn)
    (|fault_flags) |=> !fault_flag_pin_oe_n)
    else $error("fault pin not asserted");
  a_reinit_clears : assert property (@(posedge clock) disable iff (!resetn)
    reinit |=> open_load_config == SSW_CONFIG_RESET && fault_flags == 12'h000)
    else $error("state kept below lower threshold");
  a_latch_off : assert property (@(posedge clock) disable iff (!resetn)
    (wr_cur_limit && !reinit) |-> ##2 config_out.ls_latch_off_enable == $past(rx_data[11:4], 2))
    else $error("latch-off enable not forwarded");
  a_ot_latch : assert property (@(posedge clock) disable iff (!resetn)
    (ot_set != 12'h000 && !reinit) |=> (fault_flags & $past(ot_set)) == $past(ot_set))
    else $error("overtemperature fault not latched");
  a_fault_rearm : assert property (@(posedge clock) disable iff (!resetn)
    (cs_rise && !reinit && fault_set == 12'h000) |=> fault_flags == 12'h000)
    else $error("fault flags not rearmed after frame");
  a_uv_off : assert property (@(posedge clock) disable iff (!resetn)
    uv_upper_s |=> !outputs_enable)
    else $error("outputs still enabled in undervoltage");
endmodule : ssw_serial_status
`default_nettype wire

// ---- dv/ssw_host_model.sv ----
// host side serial master model for the switch status block
`timescale 1ns/1ps
`default_nettype none
module ssw_host_model (
  // clock
  input wire logic clock,
  // serial link
  input wire logic serial_out,
  output var logic chip_select_n,
  output var logic serial_clock,
  output var logic serial_in
);
  initial begin
    chip_select_n = 1'b1;
    serial_clock = 1'b0;
    serial_in = 1'b0;
  end

  // caller builds whole words, address, watchdog bit
  // data set while sck low, reply read late in the high phase
  task automatic xfer(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
    rx = '0;
    @(negedge clock) chip_select_n = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      serial_in = tx[i];
      repeat (4) @(negedge clock);
      serial_clock = 1'b1;
      repeat (4) @(negedge clock);
      rx = {rx[30:0], serial_out};
      serial_clock = 1'b0;
    end
    repeat (4) @(negedge clock);
    chip_select_n = 1'b1;
    // a released data line must not look like the last bit
    serial_in = ~serial_in;
    repeat (8) @(negedge clock);
  endtask : xfer
endmodule : ssw_host_model
`default_nettype wire

// ---- dv/ssw_serial_status_tb_top.sv ----
// self-checking bench for the switch serial control and status block
`timescale 1ns/1ps
`default_nettype none
module ssw_serial_status_tb_top;
  import ssw_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  wire chip_select_n;
  wire serial_clock;
  wire serial_in;
  logic serial_out, serial_out_oe_n, outputs_enable, fault_flag_pin, fault_flag_pin_oe_n;
  // {direct_high_side_input_0, direct_high_side_input_1, fsi, direct_high_side_input_2, direct_high_side_input_3, wake}
  logic [5:0] dir = 6'h2B;
  ssw_sense_t sense = '0;
  ssw_supply_t supply = '0;
  ssw_config_t config_out;
  logic [11:0] output_control_register;
  logic echo = 1'b0;
  logic [15:0] st;
  int fails = 0;
  int checked = 0;

  always #20 clock = ~clock;

  ssw_serial_status u_dut (
    .clock(clock), .resetn(resetn),
    .chip_select_n(chip_select_n), .serial_clock(serial_clock),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
    .direct_high_side_input_0(dir[5]), .direct_high_side_input_1(dir[4]),
    .fail_safe_input(dir[3]), .direct_high_side_input_2(dir[2]),
    .direct_high_side_input_3(dir[1]), .wake_input(dir[0]),
    .sense(sense), .supply(supply), .config_out(config_out),
    .output_control_register(output_control_register), .outputs_enable(outputs_enable),
    .fault_flag_pin(fault_flag_pin), .fault_flag_pin_oe_n(fault_flag_pin_oe_n)
  );

  ssw_host_model u_host (
    .clock(clock), .serial_out(serial_out), .chip_select_n(chip_select_n),
    .serial_clock(serial_clock), .serial_in(serial_in)
  );

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic [15:0] exp_st(input logic [11:0] f);
    return {echo, (echo ? dir[2:0] : dir[5:3]), f};
  endfunction : exp_st

  task automatic word(input logic [2:0] a, input logic [11:0] d, input logic wd);
    logic [31:0] rx;
    u_host.xfer({16'h0000, wd, a, d}, 16, rx);
    st = rx[15:0];
    if (a == SSW_ADDR_OUTPUT_CTRL) echo = wd;
  endtask : word

  task automatic t_reset;
    check("config_out", config_out, 0);
    check("out_ctrl", output_control_register, 0);
    check("so_oe_n", serial_out_oe_n, 1);
    check("flag_oe_n", fault_flag_pin_oe_n, 1);
    check("flag_pin", fault_flag_pin, 0);
  endtask : t_reset

  task automatic t_config;
    logic [31:0] rx;
    word(SSW_ADDR_OPEN_LOAD_CONFIG, 12'hA5C, 1'b1);
    check("ol_cfg", config_out, {4'hC, 8'hA5, 4'h0, 8'h00});
    word(SSW_ADDR_CURRENT_LIMIT_CONFIG, 12'h3C9, 1'b0);
    check("cl_cfg", config_out, {4'hC, 8'hA5, 4'h9, 8'h3C});
    word(SSW_ADDR_TEST_RESERVED, 12'hFFF, 1'b1);
    word(SSW_ADDR_UNUSED_SLOT, 12'hFFF, 1'b0);
    check("rsvd_cfg", config_out, {4'hC, 8'hA5, 4'h9, 8'h3C});
    u_host.xfer(32'h0000_1FFF, 15, rx);
    check("short_cfg", config_out, {4'hC, 8'hA5, 4'h9, 8'h3C});
    check("so_float", serial_out_oe_n, 1);
  endtask : t_config

  task automatic t_status;
    word(SSW_ADDR_OUTPUT_CTRL, 12'h0F0, 1'b1);
    check("out_ctrl", output_control_register, 12'h0F0);
    word(SSW_ADDR_UNUSED_SLOT, 12'h000, 1'b0);
    check("status_wd1", st, exp_st(12'h000));
    word(SSW_ADDR_OUTPUT_CTRL, 12'h000, 1'b0);
    word(SSW_ADDR_UNUSED_SLOT, 12'h000, 1'b1);
    check("status_wd0", st, exp_st(12'h000));
  endtask : t_status

  task automatic t_chain;
    logic [31:0] rx;
    u_host.xfer({1'b1, SSW_ADDR_OPEN_LOAD_CONFIG, 12'h111,
                 1'b0, SSW_ADDR_OPEN_LOAD_CONFIG, 12'h222}, 32, rx);
    check("chain_st", rx[31:16], exp_st(12'h000));
    check("chain_pass", rx[15:0], {1'b1, SSW_ADDR_OPEN_LOAD_CONFIG, 12'h111});
    check("chain_cfg", config_out[23:12], 12'h222);
  endtask : t_chain

  task automatic t_faults;
    sense.over_voltage = 1'b1;
    repeat (8) @(negedge clock);
    check("flag_ov", fault_flag_pin_oe_n, 0);
    sense.over_voltage = 1'b0;
    word(SSW_ADDR_UNUSED_SLOT, 12'h000, 1'b0);
    check("ov_st", st, exp_st(SSW_ALL_FAULTS));
    word(SSW_ADDR_UNUSED_SLOT, 12'h000, 1'b0);
    check("rearm_st", st, exp_st(12'h000));
    check("flag_clr", fault_flag_pin_oe_n, 1);
    sense.output_on = 12'h004;
    sense.over_temp = 12'h004;
    repeat (8) @(negedge clock);
    sense.over_temp = 12'h000;
    word(SSW_ADDR_UNUSED_SLOT, 12'h000, 1'b0);
    check("ot_st", st, exp_st(12'h004));
    sense.output_on = 12'h000;
    word(SSW_ADDR_OPEN_LOAD_CONFIG, 12'h020, 1'b0);
    sense.open_load = 12'h020;
    word(SSW_ADDR_UNUSED_SLOT, 12'h000, 1'b0);
    check("ol_st", st, exp_st(12'h020));
    sense.output_on = 12'h020;
    word(SSW_ADDR_UNUSED_SLOT, 12'h000, 1'b0);
    word(SSW_ADDR_UNUSED_SLOT, 12'h000, 1'b0);
    check("ol_on_st", st, exp_st(12'h000));
    // high side shut down by overtemperature still reports on the next read
    sense.output_on = 12'h021;
    repeat (4) @(negedge clock);
    sense.output_on = 12'h020;
    sense.over_temp = 12'h001;
    repeat (8) @(negedge clock);
    sense.over_temp = 12'h000;
    word(SSW_ADDR_UNUSED_SLOT, 12'h000, 1'b0);
    check("hs_ot_st", st, exp_st(12'h001));
    sense = '0;
  endtask : t_faults

  task automatic t_supply;
    supply.below_upper = 1'b1;
    repeat (8) @(negedge clock);
    check("uv_off", outputs_enable, 0);
    check("uv_keep", config_out[23:12], {4'h0, 8'h02});
    supply.below_lower = 1'b1;
    repeat (8) @(negedge clock);
    check("uv_reinit", config_out, 0);
    supply = '0;
    echo = 1'b0;
    repeat (8) @(negedge clock);
    check("uv_back", outputs_enable, 1);
    word(SSW_ADDR_UNUSED_SLOT, 12'h000, 1'b0);
    check("uv_st", st, exp_st(12'h000));
  endtask : t_supply

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  // the full sequence needs well under a quarter of this span
  initial begin
    #1000000;
    fails++;
    report_and_stop();
  end

  initial begin
    repeat (16) @(negedge clock);
    resetn = 1'b1;
    repeat (4) @(negedge clock);
    t_reset();
    t_config();
    t_status();
    t_chain();
    t_faults();
    t_supply();
    report_and_stop();
  end
endmodule : ssw_serial_status_tb_top
`default_nettype wire
